/* rtl/adcph_top.sv */
// six channel converter back end: delay, ready link, flags, calibration
`timescale 1ns/1ps
module adcph_top (
  // clock and reset
  input  wire logic                clock,
  input  wire logic                rst_b,
  // avalon slave
  input  wire logic [7:0]          address,
  input  wire logic                read,
  input  wire logic                write,
  input  wire logic [3:0]          byteenable,
  input  wire logic [31:0]         writedata,
  output logic      [31:0]         readdata,
  output logic                     waitrequest,
  // converter samples
  input  wire logic [5:0][23:0]    conv_sample,
  // converter and clock control
  output logic                     conv_restart,
  output logic                     osc_enable,
  output logic                     ext_clock_select,
  // host ready pin
  output logic                     ready_pin_n
);

  // ****************************************************************
  // state
  // ****************************************************************
  typedef struct packed {
    logic [5:0][23:0] data;
    logic [5:0][23:0] offs;
    logic [5:0][23:0] gain;
    logic [5:0]       flags;
    logic             merge;
    logic             ofs_en;
    logic             gain_en;
    logic             w24;
    logic             ext;
    logic             osc_en;
    logic [2:0]       osr;
    logic [1:0]       pre;
    logic [5:0]       rst_ch;
    logic [5:0]       shdn;
    logic [11:0]      dly_lo;
    logic [23:0]      dly_hi;
    logic [11:0]      cnt;
    logic [2:0]       div;
    logic             ready_n;
    logic             restart;
    logic             waitr;
    logic [31:0]      rdata;
  } adcph_state_t;

  localparam adcph_state_t ST_RST = '{
    data:    '0,
    offs:    '0,
    gain:    '0,
    flags:   adcph_pkg::FLAGS_RST,
    merge:   adcph_pkg::MERGE_RST,
    ofs_en:  1'b0,
    gain_en: 1'b0,
    w24:     adcph_pkg::W24_RST,
    ext:     adcph_pkg::EXT_RST,
    osc_en:  ~adcph_pkg::EXT_RST,
    osr:     adcph_pkg::OSR_RST,
    pre:     adcph_pkg::PRE_RST,
    rst_ch:  6'h00,
    shdn:    6'h00,
    dly_lo:  12'h000,
    dly_hi:  24'h000000,
    cnt:     12'h000,
    div:     3'h0,
    ready_n: 1'b1,
    restart: 1'b0,
    waitr:   1'b1,
    rdata:   32'h00000000
  };

  adcph_state_t st_reg;
  adcph_state_t st_next;

  // ****************************************************************
  // byte lane merge
  // ****************************************************************
  function automatic logic [31:0] adcph_merge(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old_val;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_val[b*8 +: 8];
      end
    end
    return res;
  endfunction : adcph_merge

  // ****************************************************************
  // ready positions per channel
  // ****************************************************************
  logic [5:0][11:0] target;
  logic [5:0][23:0] cal_out;
  logic [5:0]       active;
  logic [12:0]      osr_len;
  logic [11:0]      half;
  logic [2:0][11:0] pair_code;

  assign osr_len      = adcph_pkg::OSR_MIN << st_reg.osr;
  assign half         = osr_len[12:1];
  assign active       = ~(st_reg.rst_ch | st_reg.shdn);
  assign pair_code[0] = st_reg.dly_hi[11:0];
  assign pair_code[1] = st_reg.dly_hi[23:12];
  assign pair_code[2] = st_reg.dly_lo;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_pair
      adcph_phase_target u_phase (
        .pair_delay_code (pair_code[g]),
        .osr_sel         (st_reg.osr),
        .target          (target[2*g])
      );
      assign target[2*g+1] = half;
    end
    for (g = 0; g < 6; g++) begin : g_chan
      adcph_cal u_cal (
        .raw               (conv_sample[g]),
        .chan_offset_word  (st_reg.offs[g]),
        .chan_gain_word    (st_reg.gain[g]),
        .offset_cal_enable (st_reg.ofs_en),
        .gain_cal_enable   (st_reg.gain_en),
        .active            (active[g]),
        .osr_sel           (st_reg.osr),
        .width24           (st_reg.w24),
        .result            (cal_out[g])
      );
    end
  endgenerate

  // ****************************************************************
  // next state
  // ****************************************************************
  logic        tick;
  logic [2:0]  div_lim;
  logic [11:0] max_t;
  logic        any_act;
  logic        link_ev;
  logic [5:0]  ev;
  logic        req;
  logic [31:0] wr;

  always_comb begin
    st_next = st_reg;
    div_lim = 3'((4'h1 << st_reg.pre) - 4'h1);
    tick    = (st_reg.div == div_lim);
    max_t   = 12'h000;
    any_act = 1'b0;
    ev      = 6'h00;
    for (int i = 0; i < 6; i++) begin
      if (active[i]) begin
        any_act = 1'b1;
        if (target[i] > max_t) begin
          max_t = target[i];
        end
      end
      ev[i] = tick && active[i] && (st_reg.cnt == target[i]);
    end
    link_ev = tick && any_act && (st_reg.cnt == max_t);
    req     = (read || write) && st_reg.waitr;
    wr      = 32'h00000000;

    // modulator tick divider and output period counter
    if (tick) begin
      st_next.div = 3'h0;
      if (st_reg.cnt == 12'(osr_len - 13'h0001)) begin
        st_next.cnt = 12'h000;
      end else begin
        st_next.cnt = st_reg.cnt + 12'h001;
      end
    end else begin
      st_next.div = st_reg.div + 3'h1;
    end

    // output registers
    for (int i = 0; i < 6; i++) begin
      if (!active[i]) begin
        st_next.data[i] = 24'h000000;
      end else if (st_reg.merge ? link_ev : ev[i]) begin
        st_next.data[i] = cal_out[i];
      end
    end

    // ready pin
    if (st_reg.merge) begin
      st_next.ready_n = ~link_ev;
    end else begin
      st_next.ready_n = ~(|ev);
    end

    // bus access
    st_next.waitr   = ~req;
    st_next.restart = 1'b0;
    if (req && read) begin
      unique case (address)
        adcph_pkg::STATUS_COMM_OFS: begin
          st_next.rdata = 32'h00000000;
          st_next.rdata[adcph_pkg::ST_FLAGS_LSB +: 6] = st_reg.flags;
          st_next.rdata[adcph_pkg::ST_MERGE_BIT] = st_reg.merge;
          st_next.flags = adcph_pkg::FLAGS_RST;
        end
        adcph_pkg::CONFIG_A_OFS: begin
          st_next.rdata = 32'h00000000;
          st_next.rdata[adcph_pkg::CA_OFS_BIT]  = st_reg.ofs_en;
          st_next.rdata[adcph_pkg::CA_GAIN_BIT] = st_reg.gain_en;
          st_next.rdata[adcph_pkg::CA_OSR_LSB +: 3] = st_reg.osr;
          st_next.rdata[adcph_pkg::CA_W24_BIT]  = st_reg.w24;
        end
        adcph_pkg::CONFIG_B_OFS: begin
          st_next.rdata = 32'h00000000;
          st_next.rdata[adcph_pkg::CB_EXT_BIT]  = st_reg.ext;
          st_next.rdata[adcph_pkg::CB_PRE_LSB +: 2] = st_reg.pre;
          st_next.rdata[adcph_pkg::CB_RST_LSB +: 6] = st_reg.rst_ch;
          st_next.rdata[adcph_pkg::CB_SHDN_LSB +: 6] = st_reg.shdn;
        end
        adcph_pkg::DELAY_LOW_OFS: begin
          st_next.rdata = {20'h00000, st_reg.dly_lo};
        end
        adcph_pkg::DELAY_HIGH_OFS: begin
          st_next.rdata = {8'h00, st_reg.dly_hi};
        end
        default: begin
          st_next.rdata = 32'h00000000;
          for (int i = 0; i < 6; i++) begin
            if (address == 8'(adcph_pkg::OFFSET_BASE_OFS + 4*i)) begin
              st_next.rdata = {8'h00, st_reg.offs[i]};
            end
            if (address == 8'(adcph_pkg::GAIN_BASE_OFS + 4*i)) begin
              st_next.rdata = {8'h00, st_reg.gain[i]};
            end
            if (address == 8'(adcph_pkg::DATA_BASE_OFS + 4*i)) begin
              st_next.rdata = {8'h00, st_reg.data[i]};
            end
          end
        end
      endcase
    end

    if (req && write) begin
      unique case (address)
        adcph_pkg::STATUS_COMM_OFS: begin
          wr = adcph_merge({23'h000000, st_reg.merge, 8'h00},
                           writedata, byteenable);
          st_next.merge = wr[adcph_pkg::ST_MERGE_BIT];
        end
        adcph_pkg::CONFIG_A_OFS: begin
          wr = adcph_merge({26'h0000000, st_reg.w24, st_reg.osr,
                            st_reg.gain_en, st_reg.ofs_en},
                           writedata, byteenable);
          st_next.ofs_en  = wr[adcph_pkg::CA_OFS_BIT];
          st_next.gain_en = wr[adcph_pkg::CA_GAIN_BIT];
          st_next.osr     = wr[adcph_pkg::CA_OSR_LSB +: 3];
          st_next.w24     = wr[adcph_pkg::CA_W24_BIT];
        end
        adcph_pkg::CONFIG_B_OFS: begin
          wr = adcph_merge({10'h000, st_reg.shdn, 2'h0, st_reg.rst_ch,
                            2'h0, st_reg.pre, 3'h0, st_reg.ext},
                           writedata, byteenable);
          st_next.ext    = wr[adcph_pkg::CB_EXT_BIT];
          st_next.osc_en = ~wr[adcph_pkg::CB_EXT_BIT];
          st_next.pre    = wr[adcph_pkg::CB_PRE_LSB +: 2];
          st_next.rst_ch = wr[adcph_pkg::CB_RST_LSB +: 6];
          st_next.shdn   = wr[adcph_pkg::CB_SHDN_LSB +: 6];
        end
        adcph_pkg::DELAY_LOW_OFS: begin
          wr = adcph_merge({20'h00000, st_reg.dly_lo},
                           writedata, byteenable);
          st_next.dly_lo  = wr[11:0];
          st_next.restart = 1'b1;
        end
        adcph_pkg::DELAY_HIGH_OFS: begin
          wr = adcph_merge({8'h00, st_reg.dly_hi}, writedata, byteenable);
          st_next.dly_hi  = wr[23:0];
          st_next.restart = 1'b1;
        end
        default: begin
          for (int i = 0; i < 6; i++) begin
            if (address == 8'(adcph_pkg::OFFSET_BASE_OFS + 4*i)) begin
              wr = adcph_merge({8'h00, st_reg.offs[i]},
                               writedata, byteenable);
              st_next.offs[i] = wr[23:0];
            end
            if (address == 8'(adcph_pkg::GAIN_BASE_OFS + 4*i)) begin
              wr = adcph_merge({8'h00, st_reg.gain[i]},
                               writedata, byteenable);
              st_next.gain[i] = wr[23:0];
            end
          end
        end
      endcase
    end

    // ready flags: a new result wins over a read clear
    if (st_reg.merge) begin
      if (link_ev) begin
        st_next.flags = 6'h00;
      end
    end else begin
      st_next.flags = st_next.flags & ~ev;
    end

    // restart all channels after a delay write
    if (st_next.restart) begin
      st_next.cnt     = 12'h000;
      st_next.div     = 3'h0;
      st_next.data    = '0;
      st_next.ready_n = 1'b1;
    end
  end

  // ****************************************************************
  // registers
  // ****************************************************************
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= ST_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign readdata         = st_reg.rdata;
  assign waitrequest      = st_reg.waitr;
  assign conv_restart     = st_reg.restart;
  assign osc_enable       = st_reg.osc_en;
  assign ext_clock_select = st_reg.ext;
  assign ready_pin_n      = st_reg.ready_n;

endmodule : adcph_top

/* rtl/adcph_pkg.sv */
// constants and field layout shared by the converter back end
package adcph_pkg;

  // ****************************************************************
  // sizes
  // ****************************************************************
  localparam int NCH    = 6;
  localparam int DW     = 24;
  localparam int PW     = 12;
  localparam int ADDR_W = 8;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [7:0] STATUS_COMM_OFS  = 8'h00;
  localparam logic [7:0] CONFIG_A_OFS     = 8'h04;
  localparam logic [7:0] CONFIG_B_OFS     = 8'h08;
  localparam logic [7:0] DELAY_LOW_OFS    = 8'h0c;
  localparam logic [7:0] DELAY_HIGH_OFS   = 8'h10;
  localparam logic [7:0] OFFSET_BASE_OFS  = 8'h14;
  localparam logic [7:0] GAIN_BASE_OFS    = 8'h2c;
  localparam logic [7:0] DATA_BASE_OFS    = 8'h44;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int ST_FLAGS_LSB  = 0;
  localparam int ST_MERGE_BIT  = 8;
  localparam int CA_OFS_BIT    = 0;
  localparam int CA_GAIN_BIT   = 1;
  localparam int CA_OSR_LSB    = 2;
  localparam int CA_W24_BIT    = 5;
  localparam int CB_EXT_BIT    = 0;
  localparam int CB_PRE_LSB    = 4;
  localparam int CB_RST_LSB    = 8;
  localparam int CB_SHDN_LSB   = 16;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic [5:0] FLAGS_RST = 6'h3f;
  localparam logic       MERGE_RST = 1'b1;
  localparam logic [2:0] OSR_RST   = 3'h7;
  localparam logic       W24_RST   = 1'b1;
  localparam logic [1:0] PRE_RST   = 2'h0;
  localparam logic       EXT_RST   = 1'b0;

  // ****************************************************************
  // converter figures
  // ****************************************************************
  localparam logic [12:0] OSR_MIN   = 13'h0020;
  localparam logic [2:0]  RES_SHIFT = 3'h7;

endpackage : adcph_pkg

/* rtl/adcph_phase_target.sv */
// ready position of a delayed channel from its pair delay code
`timescale 1ns/1ps
module adcph_phase_target (
  // code and ratio
  input  wire logic [11:0] pair_delay_code,
  input  wire logic [2:0]  osr_sel,
  // position within one output period
  output logic      [11:0] target
);
  logic [12:0] osr;
  logic [11:0] half;
  logic [11:0] mask;
  logic [11:0] sum;

  always_comb begin
    osr  = adcph_pkg::OSR_MIN << osr_sel;
    half = osr[12:1];
    mask = 12'(osr - 13'h0001);
    sum  = pair_delay_code + half;
    target = sum & mask;
  end

endmodule : adcph_phase_target

/* rtl/adcph_cal.sv */
// per channel offset, gain and saturation, no pipeline stage
`timescale 1ns/1ps
module adcph_cal (
  // sample and words
  input  wire logic [23:0] raw,
  input  wire logic [23:0] chan_offset_word,
  input  wire logic [23:0] chan_gain_word,
  // controls
  input  wire logic        offset_cal_enable,
  input  wire logic        gain_cal_enable,
  input  wire logic        active,
  input  wire logic [2:0]  osr_sel,
  input  wire logic        width24,
  // result
  output logic      [23:0] result
);
  logic        [23:0] ofs_m;
  logic signed [24:0] sum;
  logic signed [25:0] mult;
  logic signed [50:0] prod;
  logic signed [27:0] scaled;
  logic signed [19:0] s16;

  always_comb begin
    ofs_m = chan_offset_word &
            ~((24'h000001 << (adcph_pkg::RES_SHIFT - osr_sel)) -
              24'h000001);
    sum = signed'({raw[23], raw});
    if (offset_cal_enable && active) begin
      sum = sum + signed'({ofs_m[23], ofs_m});
    end
    mult = 26'sh0800000 + signed'({{2{chan_gain_word[23]}},
                                   chan_gain_word});
    prod = 51'(sum) * 51'(mult);
    if (gain_cal_enable && active) begin
      scaled = prod[50:23];
    end else begin
      scaled = 28'(sum);
    end
    s16 = scaled[27:8];
    if (!active) begin
      result = 24'h000000;
    end else if (width24) begin
      if (scaled > 28'sh07fffff) begin
        result = 24'h7fffff;
      end else if (scaled < -28'sh0800000) begin
        result = 24'h800000;
      end else begin
        result = scaled[23:0];
      end
    end else begin
      if (s16 > 20'sh07fff) begin
        result = 24'h007fff;
      end else if (s16 < -20'sh08000) begin
        result = 24'h008000;
      end else begin
        result = {8'h00, s16[15:0]};
      end
    end
  end

endmodule : adcph_cal

/* verif/adcph_host.sv */
// host model: avalon master transfers and ready polling
`timescale 1ns/1ps
module adcph_host (
  // clock
  input  wire logic        clock,
  // avalon master
  output logic      [7:0]  address,
  output logic             read,
  output logic             write,
  output logic      [3:0]  byteenable,
  output logic      [31:0] writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  // ready pin
  input  wire logic        ready_pin_n
);
  initial begin
    address    = 8'h00;
    read       = 1'b0;
    write      = 1'b0;
    byteenable = 4'hf;
    writedata  = 32'h0;
  end

  // request held until waitrequest is sampled low
  task automatic xfer(input logic rw, input logic [7:0] a,
                      input logic [31:0] wd, output logic [31:0] rd_d);
    @(posedge clock);
    address   <= a;
    writedata <= wd;
    read      <= rw;
    write     <= !rw;
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    rd_d = readdata;
    read  <= 1'b0;
    write <= 1'b0;
  endtask : xfer

  task automatic wr(input logic [7:0] a, input logic [31:0] wd);
    logic [31:0] x;
    xfer(1'b0, a, wd, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] rd_d);
    xfer(1'b1, a, 32'h0, rd_d);
  endtask : rd

  task automatic wait_low;
    do begin
      @(posedge clock);
    end while (ready_pin_n !== 1'b0);
  endtask : wait_low

  // data is read only once the channel flag shows zero
  task automatic poll(input int ch);
    logic [31:0] s;
    do begin
      rd(adcph_pkg::STATUS_COMM_OFS, s);
    end while (s[ch] !== 1'b0);
  endtask : poll
endmodule : adcph_host

/* verif/adcph_properties.sv */
// bus, restart and clock select checks at the top ports
`timescale 1ns/1ps
module adcph_properties (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        rst_b,
  // avalon slave
  input  wire logic [7:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest,
  // control outputs
  input  wire logic        conv_restart,
  input  wire logic        osc_enable,
  input  wire logic        ext_clock_select
);
  logic dly_wr;
  logic st_rd;
  assign dly_wr = write & waitrequest &
                  ((address == adcph_pkg::DELAY_LOW_OFS) |
                   (address == adcph_pkg::DELAY_HIGH_OFS));
  assign st_rd = read & waitrequest &
                 (address == adcph_pkg::STATUS_COMM_OFS);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_b);

  property p_ack;
    (read | write) & waitrequest |=> !waitrequest;
  endproperty
  a_ack: assert property (p_ack) else $error("no answer after request");
  property p_wait_one;
    !waitrequest |=> waitrequest;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("answer too long");
  property p_rd_stable;
    !$past(read & waitrequest) |-> $stable(readdata);
  endproperty
  a_rd_stable: assert property (p_rd_stable) else $error("readdata moved");
  property p_restart_on_write;
    dly_wr |=> conv_restart ##1 !conv_restart;
  endproperty
  a_restart_on_write: assert property (p_restart_on_write)
    else $error("no restart pulse after delay write");
  property p_restart_only;
    $rose(conv_restart) |-> $past(dly_wr);
  endproperty
  a_restart_only: assert property (p_restart_only)
    else $error("restart without delay write");
  property p_osc_follows;
    osc_enable == !ext_clock_select;
  endproperty
  a_osc_follows: assert property (p_osc_follows)
    else $error("oscillator enable wrong");
  property p_ext_write;
    write & waitrequest & (address == adcph_pkg::CONFIG_B_OFS) &
      byteenable[0] |=> ext_clock_select == $past(writedata[0]);
  endproperty
  a_ext_write: assert property (p_ext_write)
    else $error("clock select not written");
  property p_status_layout;
    st_rd |=> (readdata[31:9] == 23'h0) && (readdata[7:6] == 2'h0);
  endproperty
  a_status_layout: assert property (p_status_layout)
    else $error("status reserved bits set");
  property p_unmapped;
    read & waitrequest & (address >= 8'h5c) |=> readdata == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
endmodule : adcph_properties

bind adcph_top adcph_properties i_adcph_properties (
  .clock(clock), .rst_b(rst_b), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest),
  .conv_restart(conv_restart), .osc_enable(osc_enable),
  .ext_clock_select(ext_clock_select));

/* verif/tb_top.sv */
// self-checking bench for the converter back end
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
  begin \
    samples_checked++; \
    if ((gt) !== (ex)) begin \
      err_count++; \
      $display("MISMATCH %s exp=%h got=%h", nm, ex, gt); \
    end \
  end
module tb_top;
  // ****************************************************************
  // signals
  // ****************************************************************
  localparam logic [31:0] FLG [3] = '{32'h3b, 32'h05, 32'h3e};
  logic             clock = 1'b0;
  logic             rst_b = 1'b0;
  logic [7:0]       address;
  logic             read;
  logic             write;
  logic [3:0]       byteenable;
  logic [31:0]      writedata;
  logic [31:0]      readdata;
  logic             waitrequest;
  logic [5:0][23:0] conv_sample;
  logic             conv_restart;
  logic             osc_enable;
  logic             ext_clock_select;
  logic             ready_pin_n;
  logic [31:0]      d;
  int               err_count = 0;
  int               samples_checked = 0;
  int               restarts = 0;

  always #25 clock = ~clock;
  always @(posedge clock) if (conv_restart === 1'b1) restarts++;

  adcph_top i_adcph_top (.clock(clock), .rst_b(rst_b), .address(address),
    .read(read), .write(write), .byteenable(byteenable),
    .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
    .conv_sample(conv_sample), .conv_restart(conv_restart),
    .osc_enable(osc_enable), .ext_clock_select(ext_clock_select),
    .ready_pin_n(ready_pin_n));
  adcph_host i_adcph_host (.clock(clock), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest),
    .ready_pin_n(ready_pin_n));

  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : end_sim

  // spacing of ready pulses, matched against a cyclic pattern
  task automatic gaps(input int e [$]);
    int t [$];
    int r;
    int n;
    n = 0;
    r = 0;
    while (t.size() < e.size() + 1) begin
      @(posedge clock);
      n++;
      if (ready_pin_n === 1'b0) t.push_back(n);
    end
    for (int k = 0; k < e.size(); k++) if (t[1] - t[0] == e[k]) r = k;
    for (int k = 0; k < e.size(); k++) begin
      `CHK("gap", e[(r + k) % e.size()], t[k + 1] - t[k])
    end
  endtask : gaps

  task automatic check_data(input logic [23:0] e [6]);
    for (int k = 0; k < 6; k++) begin
      i_adcph_host.rd(8'(adcph_pkg::DATA_BASE_OFS + 4 * k), d);
      `CHK("data", e[k], d[23:0])
    end
  endtask : check_data

  // ****************************************************************
  // tests
  // ****************************************************************
  initial begin
    conv_sample <= {24'h000005, 24'h000100, 24'h000030, 24'h000020,
                    24'h000010, 24'h7fff00};
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    i_adcph_host.rd(adcph_pkg::STATUS_COMM_OFS, d);
    `CHK("status", 32'h13f, d)
    `CHK("osc", 1'b1, osc_enable)
    i_adcph_host.rd(8'hfc, d);
    `CHK("unmapped", 32'h0, d)
    i_adcph_host.wr(adcph_pkg::CONFIG_B_OFS, 32'h1);
    `CHK("clock sel", 2'b10, {ext_clock_select, osc_enable})
    i_adcph_host.wr(adcph_pkg::STATUS_COMM_OFS, 32'h0);
    i_adcph_host.wr(adcph_pkg::DELAY_HIGH_OFS, 32'h00ffd7e5);
    i_adcph_host.wr(adcph_pkg::DELAY_LOW_OFS, 32'h800);
    i_adcph_host.wr(adcph_pkg::DELAY_LOW_OFS, 32'h800);
    @(posedge clock);
    `CHK("restarts", 3, restarts)
    gaps('{2045, 3, 2021, 27});
    i_adcph_host.wr(adcph_pkg::CONFIG_A_OFS, 32'h20);
    i_adcph_host.wr(adcph_pkg::CONFIG_B_OFS, 32'h20);
    `CHK("osc", 1'b1, osc_enable)
    i_adcph_host.wr(adcph_pkg::DELAY_LOW_OFS, 32'h800);
    gaps('{12, 20, 96});
    i_adcph_host.wr(adcph_pkg::DELAY_LOW_OFS, 32'h800);
    i_adcph_host.rd(adcph_pkg::STATUS_COMM_OFS, d);
    for (int k = 0; k < 3; k++) begin
      i_adcph_host.wait_low();
      if (k == 0) i_adcph_host.wr(adcph_pkg::STATUS_COMM_OFS, 32'h3f);
      i_adcph_host.rd(adcph_pkg::STATUS_COMM_OFS, d);
      `CHK("flags", FLG[k], d)
    end
    i_adcph_host.wr(adcph_pkg::STATUS_COMM_OFS, 32'h100);
    gaps('{128});
    i_adcph_host.wait_low();
    i_adcph_host.rd(adcph_pkg::STATUS_COMM_OFS, d);
    `CHK("merged flags", 32'h100, d)
    i_adcph_host.rd(adcph_pkg::STATUS_COMM_OFS, d);
    `CHK("cleared", 32'h13f, d)
    i_adcph_host.wr(adcph_pkg::OFFSET_BASE_OFS, 32'h200);
    i_adcph_host.wr(adcph_pkg::OFFSET_BASE_OFS + 8'h04, 32'h180);
    i_adcph_host.wr(adcph_pkg::OFFSET_BASE_OFS + 8'h14, 32'hffff80);
    i_adcph_host.wr(adcph_pkg::GAIN_BASE_OFS + 8'h10, 32'h400000);
    i_adcph_host.wr(adcph_pkg::CONFIG_B_OFS, 32'h820);
    i_adcph_host.wr(adcph_pkg::CONFIG_A_OFS, 32'h23);
    i_adcph_host.rd(adcph_pkg::STATUS_COMM_OFS, d);
    i_adcph_host.poll(1);
    check_data('{24'h7fffff, 24'h190, 24'h20, 24'h0, 24'h180,
                 24'hffff85});
    i_adcph_host.wr(adcph_pkg::CONFIG_A_OFS, 32'h20);
    i_adcph_host.rd(adcph_pkg::OFFSET_BASE_OFS + 8'h04, d);
    `CHK("offset word", 32'h180, d)
    i_adcph_host.rd(adcph_pkg::STATUS_COMM_OFS, d);
    i_adcph_host.poll(1);
    check_data('{24'h7fff00, 24'h10, 24'h20, 24'h0, 24'h100,
                 24'h5});
    i_adcph_host.wr(adcph_pkg::CONFIG_A_OFS, 32'h01);
    i_adcph_host.rd(adcph_pkg::STATUS_COMM_OFS, d);
    i_adcph_host.poll(1);
    check_data('{24'h7fff, 24'h1, 24'h0, 24'h0, 24'h1,
                 24'hffff});
    end_sim();
  end

  initial begin
    repeat (60000) @(posedge clock);
    err_count++;
    end_sim();
  end
endmodule : tb_top
